// [shared/thal_defines.vh]
// constants for the temperature histogram and alarm logger
// assumes a 25 MHz clock and byte-wide register access
`ifndef THAL_DEFINES_VH
`define THAL_DEFINES_VH

// clock and timing, times in ns
`define THAL_CLK_NS 40
`define THAL_PULSE_NS 62500000
`define THAL_PERIOD_NS 500000000
`define THAL_HOLD_NS 500000000

// register map, byte addresses
`define THAL_ADDR_W 13
`define THAL_LOW_THR_ADDR 13'h000B
`define THAL_HIGH_THR_ADDR 13'h000C
`define THAL_STATUS_ADDR 13'h0014
`define THAL_LOG_BASE 13'h0220
`define THAL_LOG_LAST 13'h027F
`define THAL_HIST_BASE 13'h0800
`define THAL_HIST_LAST 13'h087F

// threshold reset values, widest possible band
`define THAL_LOW_THR_RST 8'h00
`define THAL_HIGH_THR_RST 8'hFF

// status register bit positions
`define THAL_ST_MIP 5
`define THAL_ST_UNDER 2
`define THAL_ST_OVER 1

// histogram layout
`define THAL_BINS 63
`define THAL_BIN_MAX 16'hFFFF

// alarm log layout
`define THAL_LOG_ENTRIES 12
`define THAL_HIGH_ENTRY0 5'h0C
`define THAL_DUR_MAX 8'hFF
`define THAL_DUR_ONE 8'h01

// led pattern selection
`define THAL_PAT_BOTH 2'b00
`define THAL_PAT_IN 2'b01
`define THAL_PAT_OUT 2'b10
`define THAL_PAT_ALT 2'b11

`endif

// [rtl/thal_histogram.v]
// histogram of 63 saturating 16-bit bins indexed by temperature code
// assumes sampleValid is a one-cycle pulse in the clock domain
`timescale 1ns/1ns
`include "thal_defines.vh"

module thal_histogram (
	input wire clock,
	input wire rst_n,
	input wire sampleValid,
	input wire [7:0] sampleTemp,
	input wire [5:0] rdIndex,
	output wire [15:0] rdData
);

	reg [15:0] binMem [0:`THAL_BINS-1];
	wire [5:0] binIdx;
	integer i;

	// bin number drops the two low code bits
	assign binIdx = sampleTemp[7:2];

	// the 64th slot reads as zero
	assign rdData = (rdIndex < `THAL_BINS) ? binMem[rdIndex] : 16'h0000;

	// count the sample, holding at full scale
	always @(posedge clock) begin
		if (!rst_n) begin
			for (i = 0; i < `THAL_BINS; i = i + 1) begin
				binMem[i] <= 16'h0000;
			end
		end else if (sampleValid && (binIdx < `THAL_BINS)) begin
			if (binMem[binIdx] != `THAL_BIN_MAX) begin
				binMem[binIdx] <= binMem[binIdx] + 16'h0001;
			end
		end
	end

endmodule

// [rtl/thal_led_pulser.v]
// four-pulse generator for the two active-low status leds
// assumes go is a pulse; requests while busy are dropped
`timescale 1ns/1ns
`include "thal_defines.vh"

module thal_led_pulser #(
	parameter PULSE_CYC = 1562500,
	parameter PERIOD_CYC = 12500000
) (
	input wire clock,
	input wire rst_n,
	input wire go,
	input wire [1:0] pattern,
	output reg inSpecLedN_r,
	output reg outSpecLedN_r,
	output reg busy_r
);

	reg [23:0] tick_r;
	reg [1:0] pulseNum_r;
	reg [1:0] pat_r;
	wire lowPhase;
	wire pulseIn;
	wire pulseOut;

	// low during the first part of each half-second slot
	assign lowPhase = busy_r && (tick_r < PULSE_CYC[23:0]);
	assign pulseIn = (pat_r == `THAL_PAT_BOTH) || (pat_r == `THAL_PAT_IN) ||
		((pat_r == `THAL_PAT_ALT) && pulseNum_r[0]);
	assign pulseOut = (pat_r == `THAL_PAT_BOTH) || (pat_r == `THAL_PAT_OUT) ||
		((pat_r == `THAL_PAT_ALT) && !pulseNum_r[0]);

	// slot timer and pulse count
	always @(posedge clock) begin
		if (!rst_n) begin
			tick_r <= 24'h00_0000;
			pulseNum_r <= 2'b00;
			pat_r <= `THAL_PAT_BOTH;
			busy_r <= 1'b0;
		end else if (!busy_r) begin
			if (go) begin
				busy_r <= 1'b1;
				pat_r <= pattern;
				tick_r <= 24'h00_0000;
				pulseNum_r <= 2'b00;
			end
		end else if (tick_r == PERIOD_CYC[23:0] - 24'h00_0001) begin
			tick_r <= 24'h00_0000;
			pulseNum_r <= pulseNum_r + 2'b01;
			if (pulseNum_r == 2'b11) begin
				busy_r <= 1'b0; // four pulses done
			end
		end else begin
			tick_r <= tick_r + 24'h00_0001;
		end
	end

	// outputs idle high between indications
	always @(posedge clock) begin
		if (!rst_n) begin
			inSpecLedN_r <= 1'b1;
			outSpecLedN_r <= 1'b1;
		end else begin
			inSpecLedN_r <= !(lowPhase && pulseIn);
			outSpecLedN_r <= !(lowPhase && pulseOut);
		end
	end

endmodule

// [rtl/thal_logger.v]
// temperature alarm logger: thresholds, flags, alarm log, histogram, leds
// assumes a byte-wide register port driven by the serial front end,
// samples as one-cycle pulses, and a 25 MHz clock
`timescale 1ns/1ns
`include "thal_defines.vh"

// Behaviour
// - count each completed sample taken during a mission in one of 63 16-bit bins
// - bin n is at 0800h plus 2n, low byte first
// - bin index is the temperature code shifted right by two
// - the slot of a 64th bin always reads zero
// - bins saturate at 65535 instead of wrapping
// - compare against low and high thresholds; strictly inside means no alarm
// - an out-of-band sample sets the over or under flag in status
// - interrupt low only for flags whose enable is set
// - a new alarm period stores the three-byte sample counter, low byte first
// - the byte above each stamp counts out-of-band samples in that period
// - a full duration count opens a fresh entry while still out of band
// - returning in band stops the count; next crossing opens a new entry
// - under-temperature entries live at 0220h to 024Fh, twelve entries
// - over-temperature entries live at 0250h to 027Fh, twelve entries
// - each indication is four low pulses of 62.5 ms every half second
// - mission start pulses both leds together
// - status request pulses in-spec if clean, otherwise out-of-spec
// - request during a mission before its first sample alternates, out-of-spec first
// - temperature code is an unsigned byte, half-degree steps from -40
// - full datalog does not stop histogram or alarms
module thal_logger #(
	parameter PULSE_CYC = `THAL_PULSE_NS / `THAL_CLK_NS,
	parameter PERIOD_CYC = `THAL_PERIOD_NS / `THAL_CLK_NS,
	parameter HOLD_CYC = (`THAL_HOLD_NS + `THAL_CLK_NS - 1) / `THAL_CLK_NS
) (
	input wire clock,
	input wire rst_n,
	input wire [12:0] regAddr,
	input wire [7:0] regWrData,
	input wire regWr,
	input wire regRd,
	output reg [7:0] regRdData_r,
	input wire sampleValid,
	input wire [7:0] sampleTemp,
	input wire [23:0] sampleCount,
	input wire missionActive,
	input wire missionStart,
	input wire specTestCmd,
	input wire startButtonN,
	input wire overTempIrqEnable,
	input wire underTempIrqEnable,
	output reg intN_r,
	output wire inSpecLedN,
	output wire outSpecLedN
);

	reg [7:0] lowThr_r;
	reg [7:0] highThr_r;
	reg overFlag_r;
	reg underFlag_r;
	reg [31:0] logMem [0:2*`THAL_LOG_ENTRIES-1];
	reg [3:0] lowIdx_r;
	reg [3:0] highIdx_r;
	reg lowOpen_r;
	reg highOpen_r;
	reg [7:0] lowDur_r;
	reg [7:0] highDur_r;
	reg anyOut_r;
	reg sampled_r;
	reg [23:0] holdCnt_r;
	reg holdArmed_r;
	reg statusReq_r;
	wire isLow;
	wire isHigh;
	wire statusWr;
	wire [15:0] binData;
	wire ledBusy;
	wire ledGo;
	wire [1:0] ledPat;
	wire [12:0] logOff;
	integer i;

	// byte select from a 16-bit word
	function [7:0] pickByte16;
		input [15:0] word;
		input sel;
		begin
			pickByte16 = sel ? word[15:8] : word[7:0];
		end
	endfunction

	// byte select from a 32-bit log entry
	function [7:0] pickByte32;
		input [31:0] word;
		input [1:0] sel;
		begin
			case (sel)
				2'b00: pickByte32 = word[7:0];
				2'b01: pickByte32 = word[15:8];
				2'b10: pickByte32 = word[23:16];
				default: pickByte32 = word[31:24];
			endcase
		end
	endfunction

	// address window test
	function inRange;
		input [12:0] addr;
		input [12:0] lo;
		input [12:0] hi;
		begin
			inRange = (addr >= lo) && (addr <= hi);
		end
	endfunction

	// code is unsigned half-degree steps, so plain compares work
	assign isLow = sampleValid && (sampleTemp <= lowThr_r);
	assign isHigh = sampleValid && (sampleTemp >= highThr_r);
	assign statusWr = regWr && (regAddr == `THAL_STATUS_ADDR);
	assign logOff = regAddr - `THAL_LOG_BASE;

	// histogram keeps counting whatever the datalog state
	thal_histogram uHist (
		.clock(clock),
		.rst_n(rst_n),
		.sampleValid(sampleValid && missionActive),
		.sampleTemp(sampleTemp),
		.rdIndex(regAddr[6:1]),
		.rdData(binData)
	);

	// threshold registers
	always @(posedge clock) begin
		if (!rst_n) begin
			lowThr_r <= `THAL_LOW_THR_RST;
			highThr_r <= `THAL_HIGH_THR_RST;
		end else if (regWr) begin
			if (regAddr == `THAL_LOW_THR_ADDR) begin
				lowThr_r <= regWrData;
			end
			if (regAddr == `THAL_HIGH_THR_ADDR) begin
				highThr_r <= regWrData;
			end
		end
	end

	// alarm flags: writing zero clears, a new alarm wins over the clear
	always @(posedge clock) begin
		if (!rst_n) begin
			overFlag_r <= 1'b0;
			underFlag_r <= 1'b0;
		end else begin
			if (isHigh) begin
				overFlag_r <= 1'b1;
			end else if (statusWr && !regWrData[`THAL_ST_OVER]) begin
				overFlag_r <= 1'b0;
			end
			if (isLow) begin
				underFlag_r <= 1'b1;
			end else if (statusWr && !regWrData[`THAL_ST_UNDER]) begin
				underFlag_r <= 1'b0;
			end
		end
	end

	// interrupt pin, active low
	always @(posedge clock) begin
		if (!rst_n) begin
			intN_r <= 1'b1;
		end else begin
			intN_r <= !((overFlag_r && overTempIrqEnable) ||
				(underFlag_r && underTempIrqEnable));
		end
	end

	// under-temperature period tracking and log entries
	always @(posedge clock) begin
		if (!rst_n) begin
			lowIdx_r <= 4'h0;
			lowOpen_r <= 1'b0;
			lowDur_r <= 8'h00;
		end else if (missionStart) begin
			lowIdx_r <= 4'h0;
			lowOpen_r <= 1'b0;
			lowDur_r <= 8'h00;
		end else if (sampleValid && !isLow) begin
			lowOpen_r <= 1'b0;
		end else if (isLow && lowOpen_r && (lowDur_r != `THAL_DUR_MAX)) begin
			lowDur_r <= lowDur_r + 8'h01;
		end else if (isLow && (lowIdx_r < `THAL_LOG_ENTRIES)) begin
			lowOpen_r <= 1'b1;
			lowDur_r <= `THAL_DUR_ONE;
			lowIdx_r <= lowIdx_r + 4'h1;
		end else if (isLow) begin
			lowOpen_r <= 1'b0; // log full
		end
	end

	// over-temperature period tracking and log entries
	always @(posedge clock) begin
		if (!rst_n) begin
			highIdx_r <= 4'h0;
			highOpen_r <= 1'b0;
			highDur_r <= 8'h00;
		end else if (missionStart) begin
			highIdx_r <= 4'h0;
			highOpen_r <= 1'b0;
			highDur_r <= 8'h00;
		end else if (sampleValid && !isHigh) begin
			highOpen_r <= 1'b0;
		end else if (isHigh && highOpen_r && (highDur_r != `THAL_DUR_MAX)) begin
			highDur_r <= highDur_r + 8'h01;
		end else if (isHigh && (highIdx_r < `THAL_LOG_ENTRIES)) begin
			highOpen_r <= 1'b1;
			highDur_r <= `THAL_DUR_ONE;
			highIdx_r <= highIdx_r + 4'h1;
		end else if (isHigh) begin
			highOpen_r <= 1'b0;
		end
	end

	// log memory: stamp in bytes 0..2, duration in byte 3
	always @(posedge clock) begin
		if (!rst_n) begin
			for (i = 0; i < 2 * `THAL_LOG_ENTRIES; i = i + 1) begin
				logMem[i] <= 32'h0000_0000;
			end
		end else begin
			if (isLow && lowOpen_r && (lowDur_r != `THAL_DUR_MAX)) begin
				logMem[lowIdx_r - 4'h1][31:24] <= lowDur_r + 8'h01;
			end else if (isLow && (!lowOpen_r || (lowDur_r == `THAL_DUR_MAX)) &&
				(lowIdx_r < `THAL_LOG_ENTRIES)) begin
				logMem[lowIdx_r] <= {`THAL_DUR_ONE, sampleCount};
			end
			if (isHigh && highOpen_r && (highDur_r != `THAL_DUR_MAX)) begin
				logMem[{1'b0, highIdx_r} + `THAL_HIGH_ENTRY0 - 5'h01][31:24] <=
					highDur_r + 8'h01;
			end else if (isHigh && (!highOpen_r || (highDur_r == `THAL_DUR_MAX)) &&
				(highIdx_r < `THAL_LOG_ENTRIES)) begin
				logMem[{1'b0, highIdx_r} + `THAL_HIGH_ENTRY0] <=
					{`THAL_DUR_ONE, sampleCount};
			end
		end
	end

	// mission summary: any out-of-band sample, any sample at all
	always @(posedge clock) begin
		if (!rst_n) begin
			anyOut_r <= 1'b0;
			sampled_r <= 1'b0;
		end else if (missionStart) begin
			anyOut_r <= 1'b0;
			sampled_r <= 1'b0;
		end else if (sampleValid && missionActive) begin
			sampled_r <= 1'b1;
			if (isLow || isHigh) begin
				anyOut_r <= 1'b1;
			end
		end
	end

	// start button held half a second during a mission asks for status
	always @(posedge clock) begin
		if (!rst_n) begin
			holdCnt_r <= 24'h00_0000;
			holdArmed_r <= 1'b0;
			statusReq_r <= 1'b0;
		end else begin
			statusReq_r <= 1'b0;
			if (startButtonN || !missionActive) begin
				holdCnt_r <= 24'h00_0000;
				holdArmed_r <= startButtonN && missionActive;
			end else if (holdArmed_r) begin
				if (holdCnt_r == HOLD_CYC[23:0] - 24'h00_0001) begin
					statusReq_r <= 1'b1;
					holdArmed_r <= 1'b0;
				end else begin
					holdCnt_r <= holdCnt_r + 24'h00_0001;
				end
			end
			if (specTestCmd) begin
				statusReq_r <= 1'b1;
			end
		end
	end

	// choose the led pattern; mission start takes precedence
	assign ledGo = missionStart || statusReq_r;
	assign ledPat = missionStart ? `THAL_PAT_BOTH :
		(missionActive && !sampled_r) ? `THAL_PAT_ALT :
		anyOut_r ? `THAL_PAT_OUT : `THAL_PAT_IN;

	thal_led_pulser #(
		.PULSE_CYC(PULSE_CYC),
		.PERIOD_CYC(PERIOD_CYC)
	) uLed (
		.clock(clock),
		.rst_n(rst_n),
		.go(ledGo),
		.pattern(ledPat),
		.inSpecLedN_r(inSpecLedN),
		.outSpecLedN_r(outSpecLedN),
		.busy_r(ledBusy)
	);

	// register read data, zero for unmapped addresses
	always @(posedge clock) begin
		if (!rst_n) begin
			regRdData_r <= 8'h00;
		end else if (regRd) begin
			if (regAddr == `THAL_LOW_THR_ADDR) begin
				regRdData_r <= lowThr_r;
			end else if (regAddr == `THAL_HIGH_THR_ADDR) begin
				regRdData_r <= highThr_r;
			end else if (regAddr == `THAL_STATUS_ADDR) begin
				regRdData_r <= ({7'h00, missionActive} << `THAL_ST_MIP) |
					({7'h00, underFlag_r} << `THAL_ST_UNDER) |
					({7'h00, overFlag_r} << `THAL_ST_OVER);
			end else if (inRange(regAddr, `THAL_LOG_BASE, `THAL_LOG_LAST)) begin
				regRdData_r <= pickByte32(logMem[logOff[6:2]], logOff[1:0]);
			end else if (inRange(regAddr, `THAL_HIST_BASE, `THAL_HIST_LAST)) begin
				regRdData_r <= pickByte16(binData, regAddr[0]);
			end else begin
				regRdData_r <= 8'h00;
			end
		end
	end

endmodule

// [test/thal_assertions.sv]
// concurrent checks on the logger ports
// assumes a bind onto thal_logger with its count parameters
`timescale 1ns/1ns
module thal_assertions #(
	parameter PULSE_CYC = 4,
	parameter PERIOD_CYC = 16,
	parameter HOLD_CYC = 8
) (
	input wire clock,
	input wire rst_n,
	input wire [12:0] regAddr,
	input wire [7:0] regWrData,
	input wire regWr,
	input wire regRd,
	input wire [7:0] regRdData_r,
	input wire sampleValid,
	input wire missionActive,
	input wire missionStart,
	input wire specTestCmd,
	input wire startButtonN,
	input wire overTempIrqEnable,
	input wire underTempIrqEnable,
	input wire intN_r,
	input wire inSpecLedN,
	input wire outSpecLedN
);
	reg [31:0] quietCnt_r;
	reg sawSample_r;
	wire ledsIdle = inSpecLedN && outSpecLedN;
	wire quiet = quietCnt_r >= PERIOD_CYC;
	// idle cycles with no request, so no pattern can be running
	always @(posedge clock) begin
		if (!rst_n || !ledsIdle || missionStart || specTestCmd || !startButtonN)
			quietCnt_r <= 32'h0000_0000;
		else if (!quiet)
			quietCnt_r <= quietCnt_r + 32'h0000_0001;
	end
	// any sample since the mission began
	always @(posedge clock) begin
		if (!rst_n || missionStart)
			sawSample_r <= 1'b0;
		else if (sampleValid)
			sawSample_r <= 1'b1;
	end
	default clocking dc @(posedge clock);
	endclocking
	default disable iff (!rst_n);
	sequence outOnly;
		!outSpecLedN && inSpecLedN;
	endsequence
	sequence inOnly;
		!inSpecLedN && outSpecLedN;
	endsequence
	sequence bothPulse;
		(!inSpecLedN && !outSpecLedN)[*4] ##1 ledsIdle[*8] ##1 ledsIdle[*4];
	endsequence
	property altP;
		specTestCmd && quiet && missionActive && !sawSample_r |-> ##3 outOnly[*4] ##13 inOnly;
	endproperty
	property statusP;
		regRd && regAddr == 13'h0014
		|=> (regRdData_r & 8'hD9) == 8'h00 && regRdData_r[5] == $past(missionActive);
	endproperty
	property thrP;
		regWr && regAddr == 13'h000B ##1 regRd && regAddr == 13'h000B
		|=> regRdData_r == $past(regWrData, 2);
	endproperty
	reset_idle_a: assert property ($rose(rst_n) |-> intN_r && ledsIdle)
		else $error("outputs not idle after reset");
	start_both_a: assert property (missionStart && quiet |-> ##2 bothPulse ##1 !inSpecLedN)
		else $error("start pattern wrong");
	one_led_a: assert property (specTestCmd && quiet |-> ##3 (inSpecLedN != outSpecLedN)[*4])
		else $error("status pulse on both leds");
	alt_first_a: assert property (altP)
		else $error("alternate pattern wrong");
	irq_masked_a: assert property ((!overTempIrqEnable && !underTempIrqEnable)[*3] |-> intN_r)
		else $error("interrupt while disabled");
	gap_zero_a: assert property (regRd && regAddr[12:1] == 12'h043F |=> regRdData_r == 8'h00)
		else $error("spare bin not zero");
	status_bits_a: assert property (statusP)
		else $error("status bits wrong");
	thr_write_a: assert property (thrP)
		else $error("threshold write lost");
endmodule

bind thal_logger thal_assertions #(
	.PULSE_CYC(PULSE_CYC), .PERIOD_CYC(PERIOD_CYC), .HOLD_CYC(HOLD_CYC)
) u_thal_assertions (
	.clock(clock), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
	.regWr(regWr), .regRd(regRd), .regRdData_r(regRdData_r), .sampleValid(sampleValid),
	.missionActive(missionActive), .missionStart(missionStart), .specTestCmd(specTestCmd),
	.startButtonN(startButtonN), .overTempIrqEnable(overTempIrqEnable),
	.underTempIrqEnable(underTempIrqEnable), .intN_r(intN_r), .inSpecLedN(inSpecLedN),
	.outSpecLedN(outSpecLedN)
);

// [test/thal_host_model.sv]
// host, sample source and start button facing the logger
// assumes its tasks are called at falling clock edges
`timescale 1ns/1ns
module thal_host_model (
	input wire clock,
	output wire [12:0] regAddr,
	output wire [7:0] regWrData,
	output wire regWr,
	output wire regRd,
	input wire [7:0] regRdData_r,
	output wire sampleValid,
	output wire [7:0] sampleTemp,
	output wire [23:0] sampleCount,
	output wire missionStart,
	output wire specTestCmd,
	output wire startButtonN
);
	reg [12:0] addr_r;
	reg [7:0] wrData_r;
	reg wr_r;
	reg rd_r;
	reg valid_r;
	reg [7:0] temp_r;
	reg [23:0] count_r;
	reg start_r;
	reg spec_r;
	reg button_r;
	// pins follow the model's own state
	assign regAddr = addr_r;
	assign regWrData = wrData_r;
	assign regWr = wr_r;
	assign regRd = rd_r;
	assign sampleValid = valid_r;
	assign sampleTemp = temp_r;
	assign sampleCount = count_r;
	assign missionStart = start_r;
	assign specTestCmd = spec_r;
	assign startButtonN = button_r;
	// idle levels, button released
	initial begin
		addr_r = 13'h0000;
		wrData_r = 8'h00;
		wr_r = 1'b0;
		rd_r = 1'b0;
		valid_r = 1'b0;
		temp_r = 8'h00;
		count_r = 24'h01_0203;
		start_r = 1'b0;
		spec_r = 1'b0;
		button_r = 1'b1;
	end
	// one-cycle write; data turned over once released
	task wr(input [12:0] a, input [7:0] v);
	begin
		addr_r = a;
		wrData_r = v;
		wr_r = 1'b1;
		@(negedge clock);
		wr_r = 1'b0;
		wrData_r = ~v;
	end
	endtask
	// read strobe, data taken a cycle later
	task rd(input [12:0] a, output [7:0] v);
	begin
		addr_r = a;
		rd_r = 1'b1;
		@(negedge clock);
		rd_r = 1'b0;
		@(negedge clock);
		v = regRdData_r;
	end
	endtask
	// one completed sample, codes within 00h..FAh
	task smp(input [7:0] t);
	begin
		temp_r = t;
		valid_r = 1'b1;
		@(negedge clock);
		valid_r = 1'b0;
		temp_r = ~t;
		count_r = count_r + 24'h00_0001;
		@(negedge clock);
	end
	endtask
	// mission start or status command pulse
	task cmd(input s);
	begin
		if (s)
			spec_r = 1'b1;
		else
			start_r = 1'b1;
		@(negedge clock);
		spec_r = 1'b0;
		start_r = 1'b0;
	end
	endtask
	// status request by holding the button down
	task press(input integer n);
	begin
		button_r = 1'b0;
		repeat (n) @(negedge clock);
		button_r = 1'b1;
	end
	endtask
endmodule

// [test/thal_logger_tb.sv]
// bench for the temperature alarm logger
// assumes short counts: pulse 4, period 16, hold 8 cycles
`timescale 1ns/1ns
module thal_logger_tb;
	reg clock;
	reg rst_n;
	reg missionActive;
	reg overTempIrqEnable;
	reg underTempIrqEnable;
	wire [12:0] regAddr;
	wire [7:0] regWrData;
	wire regWr;
	wire regRd;
	wire [7:0] regRdData_r;
	wire sampleValid;
	wire [7:0] sampleTemp;
	wire [23:0] sampleCount;
	wire missionStart;
	wire specTestCmd;
	wire startButtonN;
	wire intN_r;
	wire inSpecLedN;
	wire outSpecLedN;
	integer n_fail;
	integer n_checks;
	integer i;
	integer nIn;
	integer nOut;
	reg [7:0] d;
	reg [23:0] st;
	thal_logger #(.PULSE_CYC(4), .PERIOD_CYC(16), .HOLD_CYC(8)) u_thal_logger (
		.clock(clock), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
		.regWr(regWr), .regRd(regRd), .regRdData_r(regRdData_r), .sampleValid(sampleValid),
		.sampleTemp(sampleTemp), .sampleCount(sampleCount), .missionActive(missionActive),
		.missionStart(missionStart), .specTestCmd(specTestCmd), .startButtonN(startButtonN),
		.overTempIrqEnable(overTempIrqEnable), .underTempIrqEnable(underTempIrqEnable),
		.intN_r(intN_r), .inSpecLedN(inSpecLedN), .outSpecLedN(outSpecLedN)
	);
	thal_host_model u_host (
		.clock(clock), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
		.regRd(regRd), .regRdData_r(regRdData_r), .sampleValid(sampleValid),
		.sampleTemp(sampleTemp), .sampleCount(sampleCount), .missionStart(missionStart),
		.specTestCmd(specTestCmd), .startButtonN(startButtonN)
	);
	always #20 clock = ~clock;
	// compare and count
	task chk(input string nm, input [7:0] e, input [7:0] g);
	begin
		n_checks = n_checks + 1;
		if (g !== e) begin
			n_fail = n_fail + 1;
			$display("MISMATCH %0s expected %h seen %h", nm, e, g);
		end
	end
	endtask
	task rdc(input [12:0] a, input [7:0] e);
	begin
		u_host.rd(a, d);
		chk($sformatf("addr %h", a), e, d);
	end
	endtask
	// count low cycles of each led; optional status poke
	task watch(input integer poke, input integer eIn, input integer eOut);
	begin
		nIn = 0;
		nOut = 0;
		for (i = 0; i < 96; i = i + 1) begin
			nIn = nIn + (inSpecLedN === 1'b0);
			nOut = nOut + (outSpecLedN === 1'b0);
			if (i == poke)
				u_host.cmd(1'b1);
			else
				@(negedge clock);
		end
		chk("in led lows", eIn, nIn[7:0]);
		chk("out led lows", eOut, nOut[7:0]);
	end
	endtask
	task results;
	begin
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	end
	endtask
	initial begin
		clock = 1'b0;
		rst_n = 1'b0;
		missionActive = 1'b0;
		overTempIrqEnable = 1'b0;
		underTempIrqEnable = 1'b0;
		n_fail = 0;
		n_checks = 0;
		repeat (16) @(negedge clock);
		rst_n = 1'b1;
		chk("irq idle", 8'h01, {7'h00, intN_r});
		// thresholds, an unmapped place, status
		rdc(13'h000B, 8'h00);
		rdc(13'h000C, 8'hFF);
		u_host.wr(13'h000B, 8'h20);
		rdc(13'h000B, 8'h20);
		u_host.wr(13'h000C, 8'hC0);
		rdc(13'h000C, 8'hC0);
		u_host.wr(13'h0100, 8'h55);
		rdc(13'h0100, 8'h00);
		rdc(13'h0014, 8'h00);
		$display("test registers done");
		// start pattern; a request inside it is dropped
		repeat (4) @(negedge clock); // leds quiet long enough for the checker
		missionActive = 1'b1;
		u_host.cmd(1'b0);
		watch(20, 16, 16);
		u_host.cmd(1'b1);
		watch(-1, 8, 8);
		$display("test start and early status done");
		// in-band samples, boundary codes next to the thresholds
		for (i = 0; i < 6; i = i + 1)
			u_host.smp(48'h2140_4143_44BF >> (8 * i));
		rdc(13'h0820, 8'h03);
		rdc(13'h0821, 8'h00);
		rdc(13'h0822, 8'h01);
		rdc(13'h0810, 8'h01);
		rdc(13'h085E, 8'h01);
		rdc(13'h0014, 8'h20);
		u_host.cmd(1'b1);
		watch(-1, 16, 0);
		$display("test histogram done");
		// under-temperature periods
		underTempIrqEnable = 1'b1;
		st = sampleCount;
		u_host.smp(8'h20);
		u_host.smp(8'h10);
		u_host.smp(8'h40);
		u_host.smp(8'h00);
		rdc(13'h0014, 8'h24);
		chk("irq low", 8'h00, {7'h00, intN_r});
		rdc(13'h0220, st[7:0]);
		rdc(13'h0221, st[15:8]);
		rdc(13'h0222, st[23:16]);
		rdc(13'h0223, 8'h02);
		st = st + 24'h00_0003;
		rdc(13'h0224, st[7:0]);
		rdc(13'h0227, 8'h01);
		// over-temperature period at the top code
		st = sampleCount;
		u_host.smp(8'hFA);
		rdc(13'h0250, st[7:0]);
		rdc(13'h0253, 8'h01);
		rdc(13'h087C, 8'h01);
		rdc(13'h087E, 8'h00);
		rdc(13'h0014, 8'h26);
		u_host.wr(13'h0014, 8'h20);
		rdc(13'h0014, 8'h20);
		chk("irq cleared", 8'h01, {7'h00, intN_r});
		u_host.smp(8'hFA);
		rdc(13'h0014, 8'h22);
		chk("irq masked", 8'h01, {7'h00, intN_r});
		overTempIrqEnable = 1'b1;
		repeat (2) @(negedge clock);
		chk("irq high", 8'h00, {7'h00, intN_r});
		overTempIrqEnable = 1'b0;
		repeat (2) @(negedge clock);
		chk("irq high off", 8'h01, {7'h00, intN_r});
		$display("test alarms done");
		// button status request after alarms
		fork
			u_host.press(9);
			watch(-1, 0, 16);
		join
		$display("test button done");
		results;
	end
endmodule
